/* File: pkg/ifds_pkg.sv */
// Shared constants and helpers of the input fault diagnostic scanner.
package ifds_pkg;

  // Register offsets.
  localparam logic [7:0] ADDR_SCAN_ENABLE = 8'h64;
  localparam logic [7:0] ADDR_TERM_BAT    = 8'h65;
  localparam logic [7:0] ADDR_GND_BIAS    = 8'h66;
  localparam logic [7:0] ADDR_RATE_DBN    = 8'h67;
  localparam logic [7:0] ADDR_AVERAGING   = 8'h68;

  // Values after reset.
  localparam logic [7:0] RST_SCAN_ENABLE = 8'h00;
  localparam logic [7:0] RST_TERM_BAT    = 8'h37;
  localparam logic [7:0] RST_GND_BIAS    = 8'h87;
  localparam logic [7:0] RST_RATE_DBN    = 8'hB8;
  localparam logic [7:0] RST_AVERAGING   = 8'h00;

  // Field positions (lowest bit of each field).
  localparam int EN_CH1_BIT     = 7;
  localparam int SE_INCL_BIT    = 1;
  localparam int AC_INCL_BIT    = 0;
  localparam int HI_CODE_LSB    = 4;
  localparam int LO_CODE_LSB    = 0;
  localparam int RATE_LSB       = 6;
  localparam int DBN_LSB        = 2;
  localparam int BAT_DBN_BIT    = 1;
  localparam int DOUBLE_BIT     = 0;
  localparam int AVG_LSB        = 6;
  localparam int LOAD_BYP_BIT   = 5;
  localparam int TEMP_BYP_BIT   = 4;
  localparam logic [7:0] AVG_WRITE_MASK = 8'hF0;

  // Threshold steps in millivolts.
  localparam logic [11:0] STEP_30_MV = 12'h01E;
  localparam logic [11:0] STEP_60_MV = 12'h03C;

  // Averaging codes.
  localparam logic [1:0] AVG_HALF    = 2'h1;
  localparam logic [1:0] AVG_QUARTER = 2'h2;

  // Debounce lengths in scans.
  localparam logic [4:0] DBN_16 = 5'h10;
  localparam logic [4:0] DBN_8  = 5'h08;
  localparam logic [4:0] DBN_4  = 5'h04;
  localparam logic [4:0] DBN_1  = 5'h01;

  // Scan repetition timing.
  localparam int          CLK_PERIOD_NS  = 5;
  localparam int          MS_TICK_NS     = 1000000;
  localparam int          MS_TICK_CYCLES = MS_TICK_NS / CLK_PERIOD_NS;
  localparam logic [3:0]  REPEAT_1_MS    = 4'h1;
  localparam logic [3:0]  REPEAT_4_MS    = 4'h4;
  localparam logic [3:0]  REPEAT_8_MS    = 4'h8;

  // Old and new samples blended by the selected weights.
  function automatic logic [11:0] avg_filter(input logic [11:0] old_v,
                                             input logic [11:0] new_v,
                                             input logic [1:0]  sel);
    logic [13:0] acc;
    acc = {2'h0, new_v};
    case (sel)
      AVG_HALF:    acc = ({2'h0, old_v} + {2'h0, new_v}) >> 1;
      AVG_QUARTER: acc = ({1'b0, old_v, 1'b0} + {2'h0, old_v}
                          + {2'h0, new_v}) >> 2;
      default:     acc = {2'h0, new_v};
    endcase
    return acc[11:0];
  endfunction : avg_filter

endpackage : ifds_pkg

/* File: pkg/ifds_chan_if.sv */
// Configuration and sample bundle from the scanner core to each channel.
`timescale 1ns/1ps
`default_nettype none
interface ifds_chan_if;
  logic [11:0] thr_term;
  logic [11:0] thr_bat;
  logic [11:0] thr_gnd;
  logic [11:0] thr_bias;
  logic [4:0]  dbn_len;
  logic [4:0]  bat_dbn_len;
  logic [1:0]  avg_sel;
  logic        se_incl;
  logic        ac_incl;
  logic [11:0] pos_mv;
  logic [11:0] neg_mv;
  logic [11:0] bat_mv;
  logic [11:0] bias_mv;
  modport src (output thr_term, thr_bat, thr_gnd, thr_bias, dbn_len,
               bat_dbn_len, avg_sel, se_incl, ac_incl, pos_mv, neg_mv,
               bat_mv, bias_mv);
  modport snk (input thr_term, thr_bat, thr_gnd, thr_bias, dbn_len,
               bat_dbn_len, avg_sel, se_incl, ac_incl, pos_mv, neg_mv,
               bat_mv, bias_mv);
endinterface : ifds_chan_if
`default_nettype wire

/* File: hdl/ifds_chan.sv */
// Per-channel filtering, threshold decision and debounce.
`timescale 1ns/1ps
`default_nettype none
module ifds_chan (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // Shared configuration and sample data
  ifds_chan_if.snk        cfg,
  // Channel strobes and wiring
  input  wire logic       sample,
  input  wire logic       single_ended,
  input  wire logic       ac_coupled,
  // Faults: 0 terminal, 1 battery, 2 ground, 3 bias
  output logic [3:0]      fault
);

  function automatic logic [11:0] absdiff(input logic [11:0] a,
                                          input logic [11:0] b);
    return (a > b) ? a - b : b - a;
  endfunction : absdiff

  logic [11:0] pos_q, pos_d, neg_q, neg_d;
  logic        incl_p, incl_n, bat_low;
  logic [3:0]  cond;
  logic [4:0]  len [4];
  logic [3:0]  fault_q, fault_d;

  always_comb begin
    pos_d   = pos_q;
    neg_d   = neg_q;
    if (sample) begin
      pos_d = ifds_pkg::avg_filter(pos_q, cfg.pos_mv, cfg.avg_sel);
      neg_d = ifds_pkg::avg_filter(neg_q, cfg.neg_mv, cfg.avg_sel);
    end
    incl_p  = !ac_coupled || cfg.ac_incl;
    incl_n  = incl_p && (!single_ended || cfg.se_incl);
    bat_low = cfg.bat_mv < cfg.bias_mv;
    cond[0] = incl_p && incl_n && (absdiff(pos_d, neg_d) < cfg.thr_term);
    cond[1] = (incl_p && (absdiff(pos_d, cfg.bat_mv) < cfg.thr_bat))
           || (incl_n && (absdiff(neg_d, cfg.bat_mv) < cfg.thr_bat));
    cond[2] = (incl_p && (pos_d < cfg.thr_gnd))
           || (incl_n && (neg_d < cfg.thr_gnd));
    cond[3] = (incl_p && (absdiff(pos_d, cfg.bias_mv) < cfg.thr_bias))
           || (incl_n && (absdiff(neg_d, cfg.bias_mv) < cfg.thr_bias));
    len[0]  = cfg.dbn_len;
    len[1]  = bat_low ? cfg.bat_dbn_len : cfg.dbn_len;
    len[2]  = cfg.dbn_len;
    len[3]  = cfg.dbn_len;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pos_q <= 12'h000;
      neg_q <= 12'h000;
    end else begin
      pos_q <= pos_d;
      neg_q <= neg_d;
    end
  end

  // A fault shows once the condition held for len consecutive scans and
  // drops at the first clean scan, so a glitch never latches a report.
  for (genvar f = 0; f < 4; f++) begin : g_fault
    logic [4:0] cnt_q, cnt_d;
    always_comb begin
      cnt_d      = cnt_q;
      fault_d[f] = fault_q[f];
      if (sample) begin
        if (cond[f]) begin
          cnt_d      = (cnt_q < len[f]) ? cnt_q + 5'h01 : cnt_q;
          fault_d[f] = (cnt_d >= len[f]);
        end else begin
          cnt_d      = 5'h00;
          fault_d[f] = 1'b0;
        end
      end
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        cnt_q      <= 5'h00;
        fault_q[f] <= 1'b0;
      end else begin
        cnt_q      <= cnt_d;
        fault_q[f] <= fault_d[f];
      end
    end
    a_fault_needs_count: assert property (@(posedge sys_clk)
      disable iff (!resetn) $rose(fault_q[f]) |-> cnt_q >= len[f])
      else $error("fault rose before the debounce count was reached");
    a_clean_scan_clears: assert property (@(posedge sys_clk)
      disable iff (!resetn) sample && !cond[f] |=> !fault_q[f] && cnt_q == 0)
      else $error("clean scan did not restart the debounce");
  end

  a_bat_low_length: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    cfg.bat_mv < cfg.bias_mv |-> len[1] == cfg.bat_dbn_len)
    else $error("battery short ignored its own debounce select");

  assign fault = fault_q;

endmodule : ifds_chan
`default_nettype wire

/* File: hdl/ifds_top.sv */
// Input fault diagnostic scanner: registers, scan sequencing, channels.
// Functional notes
// - terminal short threshold: code times 30 mV.
// - battery short threshold: code times 30 mV.
// - ground short threshold: code times 60 mV.
// - bias short threshold: code times 30 mV.
// - scan repeat: back to back, 1/4/8 ms.
// - common debounce 16, 8, 4 or none.
// - battery short, low battery: debounce 16 or 8.
// - range bit doubles every threshold.
// - averaging off, half, quarter; code 3 reserved.
// - load current bypass skips averaging.
// - overtemperature bypass skips averaging.
// - each channel scanned only when enabled.
// - single-ended negative pins scanned only if included.
// - AC-coupled pins scanned only if included.
`timescale 1ns/1ps
`default_nettype none
module ifds_top #(
  parameter int N_CH        = 4,
  parameter int TICK_CYCLES = ifds_pkg::MS_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr_en,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // Measurement handshake towards the analog front end
  output logic             meas_req,
  output logic      [1:0]  meas_ch,
  input  wire logic        meas_valid,
  input  wire logic [11:0] meas_pos_mv,
  input  wire logic [11:0] meas_neg_mv,
  input  wire logic [11:0] battery_mv,
  input  wire logic [11:0] bias_mv,
  // Channel wiring
  input  wire logic [3:0]  ch_single_ended,
  input  wire logic [3:0]  ch_ac_coupled,
  // Load current and temperature readings
  input  wire logic        load_valid,
  input  wire logic [11:0] load_sample,
  input  wire logic        temp_valid,
  input  wire logic [11:0] temp_sample,
  // Results
  output logic      [11:0] load_filt,
  output logic      [11:0] temp_filt,
  output logic      [15:0] ch_fault,
  output logic             scan_active
);

  if (N_CH != 4) begin : g_bad_nch
    $error("ifds_top serves exactly four channels");
  end
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least one");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_MEASURE, ST_WAIT} ifds_state_type;

  localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);

  // Register file.
  logic [7:0] en_q, en_d, tb_q, tb_d, gb_q, gb_d, rd_q, rd_d, av_q, av_d;
  logic [7:0] rdata_q, rdata_d;

  always_comb begin
    en_d = en_q;
    tb_d = tb_q;
    gb_d = gb_q;
    rd_d = rd_q;
    av_d = av_q;
    if (reg_wr_en) begin
      case (reg_addr)
        ifds_pkg::ADDR_SCAN_ENABLE: en_d = reg_wdata;
        ifds_pkg::ADDR_TERM_BAT:    tb_d = reg_wdata;
        ifds_pkg::ADDR_GND_BIAS:    gb_d = reg_wdata;
        ifds_pkg::ADDR_RATE_DBN:    rd_d = reg_wdata;
        ifds_pkg::ADDR_AVERAGING:
          av_d = reg_wdata & ifds_pkg::AVG_WRITE_MASK;
        default: en_d = en_q;
      endcase
    end
    case (reg_addr)
      ifds_pkg::ADDR_SCAN_ENABLE: rdata_d = en_q;
      ifds_pkg::ADDR_TERM_BAT:    rdata_d = tb_q;
      ifds_pkg::ADDR_GND_BIAS:    rdata_d = gb_q;
      ifds_pkg::ADDR_RATE_DBN:    rdata_d = rd_q;
      ifds_pkg::ADDR_AVERAGING:   rdata_d = av_q;
      default:                    rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      en_q    <= ifds_pkg::RST_SCAN_ENABLE;
      tb_q    <= ifds_pkg::RST_TERM_BAT;
      gb_q    <= ifds_pkg::RST_GND_BIAS;
      rd_q    <= ifds_pkg::RST_RATE_DBN;
      av_q    <= ifds_pkg::RST_AVERAGING;
      rdata_q <= 8'h00;
    end else begin
      en_q    <= en_d;
      tb_q    <= tb_d;
      gb_q    <= gb_d;
      rd_q    <= rd_d;
      av_q    <= av_d;
      rdata_q <= rdata_d;
    end
  end

  // Derived configuration.
  ifds_chan_if cfg ();
  logic [3:0]  ch_en;
  logic [1:0]  rate;
  logic [3:0]  period_ms;
  logic        dbl;

  function automatic logic [11:0] thr(input logic [3:0]  code,
                                      input logic [11:0] step,
                                      input logic        double);
    logic [11:0] prod;
    prod = 12'({8'h00, code} * step);
    return double ? {prod[10:0], 1'b0} : prod;
  endfunction : thr

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ch_en[i] = en_q[ifds_pkg::EN_CH1_BIT - i];
    end
    dbl          = rd_q[ifds_pkg::DOUBLE_BIT];
    cfg.thr_term = thr(tb_q[ifds_pkg::HI_CODE_LSB +: 4],
                       ifds_pkg::STEP_30_MV, dbl);
    cfg.thr_bat  = thr(tb_q[ifds_pkg::LO_CODE_LSB +: 4],
                       ifds_pkg::STEP_30_MV, dbl);
    cfg.thr_gnd  = thr(gb_q[ifds_pkg::HI_CODE_LSB +: 4],
                       ifds_pkg::STEP_60_MV, dbl);
    cfg.thr_bias = thr(gb_q[ifds_pkg::LO_CODE_LSB +: 4],
                       ifds_pkg::STEP_30_MV, dbl);
    case (rd_q[ifds_pkg::DBN_LSB +: 2])
      2'h0:    cfg.dbn_len = ifds_pkg::DBN_16;
      2'h1:    cfg.dbn_len = ifds_pkg::DBN_8;
      2'h2:    cfg.dbn_len = ifds_pkg::DBN_4;
      default: cfg.dbn_len = ifds_pkg::DBN_1;
    endcase
    cfg.bat_dbn_len = rd_q[ifds_pkg::BAT_DBN_BIT] ? ifds_pkg::DBN_8
                                                  : ifds_pkg::DBN_16;
    cfg.avg_sel = av_q[ifds_pkg::AVG_LSB +: 2];
    cfg.se_incl = en_q[ifds_pkg::SE_INCL_BIT];
    cfg.ac_incl = en_q[ifds_pkg::AC_INCL_BIT];
    cfg.pos_mv  = meas_pos_mv;
    cfg.neg_mv  = meas_neg_mv;
    cfg.bat_mv  = battery_mv;
    cfg.bias_mv = bias_mv;
    rate        = rd_q[ifds_pkg::RATE_LSB +: 2];
    case (rate)
      2'h1:    period_ms = ifds_pkg::REPEAT_1_MS;
      2'h2:    period_ms = ifds_pkg::REPEAT_4_MS;
      default: period_ms = ifds_pkg::REPEAT_8_MS;
    endcase
  end

  // Scan sequencer. The repeat period runs from the start of each scan,
  // so the scan time itself is part of the period, not added to it.
  ifds_state_type state_q, state_d;
  logic [1:0]  ch_q, ch_d;
  logic [17:0] tick_q, tick_d;
  logic [3:0]  ms_q, ms_d;
  logic        step, last_ch;

  always_comb begin
    state_d  = state_q;
    ch_d     = ch_q;
    tick_d   = (tick_q == TICK_LAST) ? 18'h00000 : tick_q + 18'h00001;
    ms_d     = (tick_q == TICK_LAST && ms_q != 4'hF) ? ms_q + 4'h1 : ms_q;
    meas_req = (state_q == ST_MEASURE) && ch_en[ch_q];
    step     = (state_q == ST_MEASURE) && (!ch_en[ch_q] || meas_valid);
    last_ch  = (ch_q == 2'h3);
    case (state_q)
      ST_IDLE: begin
        if (|ch_en) begin
          state_d = ST_MEASURE;
          ch_d    = 2'h0;
          tick_d  = 18'h00000;
          ms_d    = 4'h0;
        end
      end
      ST_MEASURE: begin
        if (step) begin
          ch_d = ch_q + 2'h1;
          if (last_ch) begin
            if (!(|ch_en)) begin
              state_d = ST_IDLE;
            end else if (rate == 2'h0) begin
              tick_d  = 18'h00000;
              ms_d    = 4'h0;
            end else begin
              state_d = ST_WAIT;
            end
          end
        end
      end
      ST_WAIT: begin
        if (ms_q >= period_ms) begin
          state_d = (|ch_en) ? ST_MEASURE : ST_IDLE;
          ch_d    = 2'h0;
          tick_d  = 18'h00000;
          ms_d    = 4'h0;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      ch_q    <= 2'h0;
      tick_q  <= 18'h00000;
      ms_q    <= 4'h0;
    end else begin
      state_q <= state_d;
      ch_q    <= ch_d;
      tick_q  <= tick_d;
      ms_q    <= ms_d;
    end
  end

  // Load current and temperature filters, each with its own bypass.
  logic [11:0] load_q, load_d, temp_q, temp_d;
  logic [1:0]  load_sel, temp_sel;

  always_comb begin
    load_sel = av_q[ifds_pkg::LOAD_BYP_BIT] ? 2'h0 : cfg.avg_sel;
    temp_sel = av_q[ifds_pkg::TEMP_BYP_BIT] ? 2'h0 : cfg.avg_sel;
    load_d   = load_valid ? ifds_pkg::avg_filter(load_q, load_sample,
                                                 load_sel) : load_q;
    temp_d   = temp_valid ? ifds_pkg::avg_filter(temp_q, temp_sample,
                                                 temp_sel) : temp_q;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      load_q <= 12'h000;
      temp_q <= 12'h000;
    end else begin
      load_q <= load_d;
      temp_q <= temp_d;
    end
  end

  for (genvar c = 0; c < 4; c++) begin : g_ch
    ifds_chan u_chan (
      .sys_clk      (sys_clk),
      .resetn       (resetn),
      .cfg          (cfg.snk),
      .sample       (meas_req && meas_valid && ch_q == 2'(c)),
      .single_ended (ch_single_ended[c]),
      .ac_coupled   (ch_ac_coupled[c]),
      .fault        (ch_fault[4*c +: 4])
    );
  end

  assign reg_rdata   = rdata_q;
  assign meas_ch     = ch_q;
  assign load_filt   = load_q;
  assign temp_filt   = temp_q;
  assign scan_active = (state_q == ST_MEASURE);

  a_req_only_enabled: assert property (@(posedge sys_clk)
    disable iff (!resetn) meas_req |-> en_q[ifds_pkg::EN_CH1_BIT - ch_q])
    else $error("scan request for a disabled channel");
  a_back_to_back: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    step && last_ch && rate == 2'h0 && (|ch_en) |=> state_q == ST_MEASURE)
    else $error("continuous scanning paused between scans");
  a_wait_period: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    state_q == ST_WAIT && state_d != ST_WAIT |-> ms_q >= period_ms)
    else $error("scan restarted before its repeat period");
  a_ground_double: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    dbl |-> cfg.thr_gnd == {8'h00, gb_q[7:4]} * 12'h078)
    else $error("ground threshold not doubled");
  a_load_bypass: assert property (@(posedge sys_clk)
    disable iff (!resetn) load_valid && av_q[ifds_pkg::LOAD_BYP_BIT]
    |=> load_q == $past(load_sample))
    else $error("load current averaged despite bypass");
  a_temp_bypass: assert property (@(posedge sys_clk)
    disable iff (!resetn) temp_valid && av_q[ifds_pkg::TEMP_BYP_BIT]
    |=> temp_q == $past(temp_sample))
    else $error("temperature averaged despite bypass");

endmodule : ifds_top
`default_nettype wire

/* File: test/ifds_afe_model.sv */
// Behavioural analog front end that answers measurement requests.
`timescale 1ns/1ps
`default_nettype none
module ifds_afe_model (
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            resetn,
  // Requests
  input  wire logic            meas_req,
  input  wire logic [1:0]      meas_ch,
  input  wire logic            slow,
  // Pin voltages per channel
  input  wire logic [3:0][11:0] pos_set,
  input  wire logic [3:0][11:0] neg_set,
  // Answer
  output logic                 meas_valid,
  output logic      [11:0]     meas_pos_mv,
  output logic      [11:0]     meas_neg_mv
);
  int dly;

  // Data is inverted once the answer is gone, so stale values never match.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meas_valid <= 1'b0;
      meas_pos_mv <= 12'h000;
      meas_neg_mv <= 12'h000;
      dly <= 0;
    end else if (meas_valid) begin
      meas_valid <= 1'b0;
      meas_pos_mv <= ~meas_pos_mv;
      meas_neg_mv <= ~meas_neg_mv;
      dly <= slow ? $urandom_range(3, 0) : 0;
    end else if (meas_req && dly > 0) begin
      dly <= dly - 1;
    end else if (meas_req) begin
      meas_valid <= 1'b1;
      meas_pos_mv <= pos_set[meas_ch];
      meas_neg_mv <= neg_set[meas_ch];
    end
  end
endmodule : ifds_afe_model
`default_nettype wire

/* File: test/ifds_top_bench.sv */
// Self-checking bench of the input fault diagnostic scanner.
`timescale 1ns/1ps
`default_nettype none
module ifds_top_bench;
  localparam int TICK = 20;
  typedef struct packed {
    logic [2:0]  kind;
    logic [15:0] val;
  } ifds_note_type;
  logic             sys_clk = 1'b0;
  logic             resetn = 1'b0;
  logic [7:0]       reg_addr = 8'h00;
  logic             reg_wr_en = 1'b0;
  logic [7:0]       reg_wdata = 8'h00;
  logic [7:0]       reg_rdata;
  logic             meas_req;
  logic [1:0]       meas_ch;
  logic             meas_valid;
  logic [11:0]      meas_pos_mv;
  logic [11:0]      meas_neg_mv;
  logic [11:0]      battery_mv = 12'hDAC;
  logic [11:0]      bias_mv = 12'h9C4;
  logic [3:0]       ch_se = 4'h0;
  logic [3:0]       ch_ac = 4'h0;
  logic             load_valid = 1'b0;
  logic [11:0]      load_sample = 12'h000;
  logic             temp_valid = 1'b0;
  logic [11:0]      temp_sample = 12'h000;
  logic [11:0]      load_filt;
  logic [11:0]      temp_filt;
  logic [15:0]      ch_fault;
  logic             scan_active;
  logic             slow = 1'b0;
  logic [3:0][11:0] pos_set = {4{12'hBB8}};
  logic [3:0][11:0] neg_set = {4{12'h5DC}};
  int               n_errors = 0;
  int               cmp_count = 0;
  int               n_take = 0;
  int               n_short = 0;
  int               cyc = 0;
  int               got;
  int               len_tab [6] = '{16, 8, 4, 1, 16, 8};
  ifds_note_type    notes [$];
  event             look;

  always #2.5 sys_clk = ~sys_clk;

  ifds_top #(.TICK_CYCLES(TICK)) i_dut (.sys_clk(sys_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .meas_req(meas_req), .meas_ch(meas_ch),
    .meas_valid(meas_valid), .meas_pos_mv(meas_pos_mv),
    .meas_neg_mv(meas_neg_mv), .battery_mv(battery_mv), .bias_mv(bias_mv),
    .ch_single_ended(ch_se), .ch_ac_coupled(ch_ac),
    .load_valid(load_valid), .load_sample(load_sample),
    .temp_valid(temp_valid), .temp_sample(temp_sample),
    .load_filt(load_filt), .temp_filt(temp_filt), .ch_fault(ch_fault),
    .scan_active(scan_active));

  ifds_afe_model i_afe (.sys_clk(sys_clk), .resetn(resetn),
    .meas_req(meas_req), .meas_ch(meas_ch), .slow(slow),
    .pos_set(pos_set), .neg_set(neg_set), .meas_valid(meas_valid),
    .meas_pos_mv(meas_pos_mv), .meas_neg_mv(meas_neg_mv));

  // A shorted channel one reading carries 1000 mV on its positive pin.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (meas_req && meas_valid) begin
      n_take <= n_take + 1;
      if (meas_ch == 2'h0 && meas_pos_mv == 12'h3E8) n_short <= n_short + 1;
    end
  end

  always @(look) begin : watch
    ifds_note_type n;
    while (notes.size() > 0) begin
      n = notes.pop_front();
      case (n.kind)
        3'h0: check({8'h00, reg_rdata}, n.val);
        3'h1: check({4'h0, load_filt}, n.val);
        3'h2: check({4'h0, temp_filt}, n.val);
        3'h3: check({8'h00, ch_fault[7:0]}, n.val);
        3'h5: check({15'h0000, scan_active}, n.val);
        default: check(16'(got), n.val);
      endcase
    end
  end

  task automatic check(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check

  task automatic note(input logic [2:0] k, input logic [15:0] v);
    notes.push_back('{k, v});
    ->look;
  endtask : note

  task automatic give_verdict();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  task automatic timeout();
    n_errors++;
    $display("Error at %0t: wait ran out", $time);
    give_verdict();
  endtask : timeout

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wr_en <= 1'b1;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    @(posedge sys_clk);
    @(negedge sys_clk);
    note(3'h0, {8'h00, e});
  endtask : rd

  task automatic wait_takes(input int k);
    int t0;
    t0 = n_take;
    for (int i = 0; i < 3000 && n_take < t0 + k; i++) @(negedge sys_clk);
    if (n_take < t0 + k) timeout();
  endtask : wait_takes

  task automatic wait_rise(output int t);
    int i;
    for (i = 0; i < 400 && meas_req === 1'b1; i++) @(negedge sys_clk);
    if (i == 400) timeout();
    for (i = 0; i < 400 && meas_req !== 1'b1; i++) @(negedge sys_clk);
    if (i == 400) timeout();
    t = cyc;
    note(3'h5, 16'h0001);
  endtask : wait_rise

  function automatic int ad(input int a, input int b);
    return a > b ? a - b : b - a;
  endfunction : ad

  function automatic int blend(input int o, input int s, input int sel);
    if (sel == 1) return (o + s) / 2;
    if (sel == 2) return (3 * o + s) / 4;
    return s;
  endfunction : blend

  initial begin : main
    int s0, t1, t2, lm, tm, sv, p, q, bt, bs, sc, c;
    logic [7:0] r1;
    logic [7:0] r2;
    logic [3:0] f;
    void'($urandom(53665));
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(8'h64, 8'h00);
    rd(8'h65, 8'h37);
    rd(8'h66, 8'h87);
    rd(8'h67, 8'hB8);
    rd(8'h68, 8'h00);
    got = n_take;
    note(3'h4, 16'h0000);
    note(3'h5, 16'h0000);
    for (int a = 0; a < 6; a++) begin
      r1 = 8'($urandom);
      r2 = a == 0 ? r1 & 8'hF3 : a == 3 ? r1 | 8'h30 : r1;
      r2 = a == 4 ? r1 & 8'hF0 : r2;
      wr(8'h64 + 8'(a), r2);
      rd(8'h64 + 8'(a), a == 4 ? r2 & 8'hF0 : a == 5 ? 8'h00 : r2);
    end
    wr(8'h68, 8'h00);
    wr(8'h65, 8'h37);
    wr(8'h66, 8'h87);
    wr(8'h64, 8'h80);
    slow <= 1'b1;
    // Each debounce run starts from clean scans so the count is known.
    for (int k = 0; k < 6; k++) begin
      wr(8'h67, k < 4 ? {4'h3, 2'(k), 2'h0} : {6'h0F, k[0], 1'b0});
      @(posedge sys_clk);
      battery_mv <= k < 4 ? 12'hDAC : 12'h41A;
      bias_mv <= k < 4 ? 12'h9C4 : 12'h7D0;
      pos_set[0] <= 12'hBB8;
      neg_set[0] <= 12'h5DC;
      wait_takes(3);
      @(posedge sys_clk);
      pos_set[0] <= 12'h3E8;
      neg_set[0] <= k < 4 ? 12'h3E8 : 12'h514;
      s0 = n_short;
      for (int i = 0; i < 3000 && ch_fault[k < 4 ? 0 : 1] !== 1'b1; i++)
        @(negedge sys_clk);
      if (ch_fault[k < 4 ? 0 : 1] !== 1'b1) timeout();
      got = n_short - s0;
      note(3'h4, 16'(len_tab[k]));
    end
    wr(8'h67, 8'h3C);
    @(posedge sys_clk);
    battery_mv <= 12'hDAC;
    bias_mv <= 12'h9C4;
    pos_set[0] <= 12'hBB8;
    neg_set[0] <= 12'h5DC;
    wait_takes(4);
    for (int k = 0; k < 4; k++) begin
      c = (k + 2) % 4;
      wr(8'h64, {6'h30, c == 1, c == 3});
      @(posedge sys_clk);
      ch_se <= {3'h0, c < 2};
      ch_ac <= {3'h0, c >= 2};
      pos_set[0] <= 12'h3E8;
      neg_set[0] <= 12'h3E8;
      wait_takes(8);
      @(negedge sys_clk);
      note(3'h3, {15'h0000, c[0]});
    end
    @(posedge sys_clk);
    ch_se <= 4'h0;
    ch_ac <= 4'h0;
    wr(8'h64, 8'h80);
    for (int k = 0; k < 24; k++) begin
      r1 = 8'($urandom);
      r2 = 8'($urandom);
      sc = $urandom_range(2, 1);
      wr(8'h65, r1);
      wr(8'h66, r2);
      wr(8'h67, {7'h1E, sc == 2});
      p = $urandom_range(1023, 0);
      q = $urandom_range(1023, 0);
      bs = $urandom_range(1023, 0);
      bt = bs + $urandom_range(1023, 0);
      @(posedge sys_clk);
      pos_set[0] <= 12'(p);
      neg_set[0] <= 12'(q);
      bias_mv <= 12'(bs);
      battery_mv <= 12'(bt);
      wait_takes(3);
      @(negedge sys_clk);
      f[0] = ad(p, q) < r1[7:4] * 30 * sc;
      f[1] = ad(p, bt) < r1[3:0] * 30 * sc || ad(q, bt) < r1[3:0] * 30 * sc;
      f[2] = p < r2[7:4] * 60 * sc || q < r2[7:4] * 60 * sc;
      f[3] = ad(p, bs) < r2[3:0] * 30 * sc || ad(q, bs) < r2[3:0] * 30 * sc;
      note(3'h3, {12'h000, f});
    end
    slow <= 1'b0;
    for (int k = 1; k < 4; k++) begin
      wr(8'h67, {2'(k), 6'h3C});
      wait_rise(t1);
      wait_rise(t1);
      wait_rise(t2);
      got = (t2 - t1 + TICK / 2) / TICK;
      note(3'h4, k == 1 ? 16'h0001 : k == 2 ? 16'h0004 : 16'h0008);
    end
    lm = 0;
    tm = 0;
    for (int k = 0; k < 8; k++) begin
      wr(8'h68, {2'(k >> 1), k[0], ~k[0], 4'h0});
      repeat (2) begin
        sv = $urandom_range(4095, 0);
        @(posedge sys_clk);
        load_valid <= 1'b1;
        temp_valid <= 1'b1;
        load_sample <= 12'(sv);
        temp_sample <= 12'(4095 - sv);
        @(posedge sys_clk);
        load_valid <= 1'b0;
        temp_valid <= 1'b0;
        @(posedge sys_clk);
        @(negedge sys_clk);
        lm = k[0] ? sv : blend(lm, sv, k >> 1);
        tm = k[0] ? blend(tm, 4095 - sv, k >> 1) : 4095 - sv;
        note(3'h1, 16'(lm));
        note(3'h2, 16'(tm));
      end
    end
    give_verdict();
  end
endmodule : ifds_top_bench
`default_nettype wire
